// *** rtl/ebs_pkg.sv ***
`default_nettype none
package ebs_pkg;
  // Clock and tick timing
  localparam int unsigned CLK_HZ      = 20_000_000;
  localparam int unsigned TICK_MS     = 10;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  // Setting widths and limits
  localparam int unsigned TIME_W   = 9;
  localparam int unsigned FREQ_W   = 16;
  localparam int unsigned CUR_W    = 5;
  localparam int unsigned CURIN_W  = 8;
  localparam logic [8:0]  TIME_MAX = 9'h1f4;
  localparam logic [15:0] FREQ_MAX = 16'he678;
  localparam logic [4:0]  CUR_MAX  = 5'h14;

  // Enable select codes
  localparam logic [1:0] EN_OFF   = 2'h0;
  localparam logic [1:0] EN_DCB   = 2'h1;
  localparam logic [1:0] EN_NODCB = 2'h2;

  // Terminal function codes
  localparam logic [7:0] FN_RELEASE = 8'h13;
  localparam logic [7:0] FN_ERROR   = 8'h14;
  localparam logic [7:0] FN_ANSWER  = 8'h2c;

  // Register offsets
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_REL_WAIT = 8'h04;
  localparam logic [7:0] OFS_ACC_DLY  = 8'h08;
  localparam logic [7:0] OFS_STP_DLY  = 8'h0c;
  localparam logic [7:0] OFS_CNF_WAIT = 8'h10;
  localparam logic [7:0] OFS_REL_FREQ = 8'h14;
  localparam logic [7:0] OFS_REL_CUR  = 8'h18;
  localparam logic [7:0] OFS_BRK_FREQ = 8'h1c;
  localparam logic [7:0] OFS_TERM     = 8'h20;
  localparam logic [7:0] OFS_STATUS   = 8'h24;
  localparam logic [7:0] OFS_INT_STAT = 8'h28;
  localparam logic [7:0] OFS_INT_MASK = 8'h2c;

  // Field positions
  localparam int unsigned CTRL_TRIP_CLR = 8;
  localparam int unsigned TERM_IN_LSB   = 0;
  localparam int unsigned TERM_OA_LSB   = 8;
  localparam int unsigned TERM_OB_LSB   = 16;
  localparam int unsigned ST_RELEASE    = 0;
  localparam int unsigned ST_ERROR      = 1;
  localparam int unsigned ST_ANSWER     = 2;
  localparam int unsigned ST_BUSY       = 3;
  localparam int unsigned ST_ASSIGNED   = 4;

  // Interrupt bits
  localparam int unsigned INT_W       = 4;
  localparam int unsigned INT_REL_ON  = 0;
  localparam int unsigned INT_REL_OFF = 1;
  localparam int unsigned INT_ERR     = 2;
  localparam int unsigned INT_DONE    = 3;

  // Reset values
  localparam logic [23:0] TERM_RST = 24'h141300;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE, ST_ACC_REL, ST_REL_WAIT, ST_CNF_ON, ST_ACC_DLY,
    ST_RUN, ST_DEC_BRK, ST_CNF_OFF, ST_STP_DLY, ST_DEC_ZERO, ST_TRIP
  } ebs_state_t;
endpackage : ebs_pkg
`default_nettype wire

// *** rtl/ebs_sync2.sv ***
`timescale 1ns/10ps
`default_nettype none
module ebs_sync2 (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic d,
  output logic      q
);
  logic meta_r;

  // Two-stage synchroniser
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : ebs_sync2
`default_nettype wire

// *** rtl/ebs_wait_timer.sv ***
`timescale 1ns/10ps
`default_nettype none
module ebs_wait_timer #(
  parameter int unsigned TICK_CYCLES = ebs_pkg::TICK_CYCLES
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      restart,
  input  wire logic [ebs_pkg::TIME_W-1:0] limit,
  output logic                           done
);
  localparam int unsigned PW = $clog2(TICK_CYCLES + 1);
  localparam logic [PW-1:0] PLAST = PW'(TICK_CYCLES - 1);

  logic [PW-1:0]             pre_r;
  logic [PW-1:0]             pre_nxt;
  logic [ebs_pkg::TIME_W-1:0] cnt_r;
  logic [ebs_pkg::TIME_W-1:0] cnt_nxt;

  // Tick prescaler and saturating tick counter
  always_comb
  begin
    pre_nxt = pre_r;
    cnt_nxt = cnt_r;
    if (restart)
    begin
      pre_nxt = '0;
      cnt_nxt = '0;
    end
    else if (pre_r == PLAST)
    begin
      pre_nxt = '0;
      if (cnt_r != '1)
        cnt_nxt = cnt_r + 1'b1;
    end
    else
      pre_nxt = pre_r + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      pre_r <= pre_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign done = (cnt_r >= limit);
endmodule : ebs_wait_timer
`default_nettype wire

// *** rtl/ebs_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module ebs_top #(
  parameter int unsigned TICK_CYCLES = ebs_pkg::TICK_CYCLES
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        run_cmd,
  input  wire logic                        pos_ctrl_active,
  input  wire logic [ebs_pkg::FREQ_W-1:0]  output_freq,
  input  wire logic [ebs_pkg::CURIN_W-1:0] output_current,
  input  wire logic                        brake_answer_back_in,
  output logic                             brake_release_out,
  output logic                             brake_error_out,
  output logic                             brake_error_trip,
  output logic                             out_term_a,
  output logic                             out_term_b,
  output logic                             freq_override,
  output logic                             freq_hold,
  output logic      [ebs_pkg::FREQ_W-1:0]  freq_target,
  output logic                             dc_brake_inhibit,
  output logic                             irq
);
  // Settings
  logic [1:0]                  en_sel_r, en_sel_nxt;
  logic [ebs_pkg::TIME_W-1:0]  rel_wait_r, rel_wait_nxt;
  logic [ebs_pkg::TIME_W-1:0]  acc_dly_r, acc_dly_nxt;
  logic [ebs_pkg::TIME_W-1:0]  stp_dly_r, stp_dly_nxt;
  logic [ebs_pkg::TIME_W-1:0]  cnf_wait_r, cnf_wait_nxt;
  logic [ebs_pkg::FREQ_W-1:0]  rel_freq_r, rel_freq_nxt;
  logic [ebs_pkg::CUR_W-1:0]   rel_cur_r, rel_cur_nxt;
  logic [ebs_pkg::FREQ_W-1:0]  brk_freq_r, brk_freq_nxt;
  logic [23:0]                 term_r, term_nxt;
  logic [ebs_pkg::INT_W-1:0]   int_stat_r, int_stat_nxt;
  logic [ebs_pkg::INT_W-1:0]   int_mask_r, int_mask_nxt;
  logic [31:0]                 prdata_nxt;
  logic                        pready_nxt;
  logic                        pslverr_nxt;
  logic                        irq_nxt;
  // Sequencer
  ebs_pkg::ebs_state_t         state_r, state_nxt;
  logic                        rel_r, rel_nxt;
  logic                        err_r, err_nxt;
  logic                        ovr_nxt, hold_nxt, dcbi_nxt;
  logic                        ta_nxt, tb_nxt;
  logic [ebs_pkg::FREQ_W-1:0]  tgt_nxt;
  logic [ebs_pkg::TIME_W-1:0]  t_limit;
  logic                        t_done;
  logic                        ab_sync;
  logic                        ab_assigned;
  logic                        wr_acc;
  logic                        trip_clr;
  logic [ebs_pkg::INT_W-1:0]   ev;

  // Answer-back pin synchroniser
  ebs_sync2 u_ab_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (brake_answer_back_in),
    .q       (ab_sync)
  );

  // Wait timer shared by all timed steps
  ebs_wait_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .restart (state_nxt != state_r),
    .limit   (t_limit),
    .done    (t_done)
  );

  // Common decodes
  assign ab_assigned = (term_r[ebs_pkg::TERM_IN_LSB +: 8]
                        == ebs_pkg::FN_ANSWER);
  assign wr_acc   = psel & penable & pready & pwrite;
  assign trip_clr = wr_acc & (paddr == ebs_pkg::OFS_CTRL)
                    & pwdata[ebs_pkg::CTRL_TRIP_CLR];

  // Saturate a time setting at its maximum
  function automatic logic [8:0] clamp_t(input logic [31:0] v);
    clamp_t = (v > 32'(ebs_pkg::TIME_MAX)) ? ebs_pkg::TIME_MAX : v[8:0];
  endfunction : clamp_t

  // Saturate a frequency setting at its maximum
  function automatic logic [15:0] clamp_f(input logic [31:0] v);
    clamp_f = (v > 32'(ebs_pkg::FREQ_MAX)) ? ebs_pkg::FREQ_MAX : v[15:0];
  endfunction : clamp_f

  // Timer limit for the current step
  always_comb
  begin
    unique case (state_r)
      ebs_pkg::ST_REL_WAIT: t_limit = rel_wait_r;
      ebs_pkg::ST_CNF_ON:   t_limit = cnf_wait_r;
      ebs_pkg::ST_CNF_OFF:  t_limit = cnf_wait_r;
      ebs_pkg::ST_ACC_DLY:  t_limit = acc_dly_r;
      ebs_pkg::ST_STP_DLY:  t_limit = stp_dly_r;
      default:              t_limit = ebs_pkg::TIME_MAX;
    endcase
  end

  // Sequencer next state and flags
  always_comb
  begin
    state_nxt = state_r;
    rel_nxt   = rel_r;
    err_nxt   = err_r;
    ev        = '0;
    unique case (state_r)
      ebs_pkg::ST_IDLE:
        if (run_cmd && en_sel_r != ebs_pkg::EN_OFF)
          state_nxt = ebs_pkg::ST_ACC_REL;
      ebs_pkg::ST_ACC_REL:
        if (!run_cmd)
          state_nxt = ebs_pkg::ST_DEC_ZERO;
        else if (output_freq >= rel_freq_r)
          state_nxt = ebs_pkg::ST_REL_WAIT;
      ebs_pkg::ST_REL_WAIT:
        if (t_done)
        begin
          if (output_current < {3'h0, rel_cur_r})
          begin
            state_nxt = ebs_pkg::ST_TRIP;
            err_nxt   = 1'b1;
            ev[ebs_pkg::INT_ERR] = 1'b1;
          end
          else
          begin
            rel_nxt   = 1'b1;
            ev[ebs_pkg::INT_REL_ON] = 1'b1;
            state_nxt = ab_assigned ? ebs_pkg::ST_CNF_ON
                                    : ebs_pkg::ST_ACC_DLY;
          end
        end
      ebs_pkg::ST_CNF_ON:
        if (ab_sync)
          state_nxt = ebs_pkg::ST_ACC_DLY;
        else if (t_done)
        begin
          state_nxt = ebs_pkg::ST_TRIP;
          rel_nxt   = 1'b0;
          err_nxt   = 1'b1;
          ev[ebs_pkg::INT_ERR] = 1'b1;
        end
      ebs_pkg::ST_ACC_DLY:
        if (t_done)
          state_nxt = ebs_pkg::ST_RUN;
      ebs_pkg::ST_RUN:
        if (!run_cmd)
          state_nxt = ebs_pkg::ST_DEC_BRK;
      ebs_pkg::ST_DEC_BRK:
        if (output_freq <= brk_freq_r)
        begin
          rel_nxt   = 1'b0;
          ev[ebs_pkg::INT_REL_OFF] = 1'b1;
          state_nxt = ab_assigned ? ebs_pkg::ST_CNF_OFF
                                  : ebs_pkg::ST_STP_DLY;
        end
      ebs_pkg::ST_CNF_OFF:
        if (!ab_sync)
          state_nxt = ebs_pkg::ST_STP_DLY;
        else if (t_done)
        begin
          state_nxt = ebs_pkg::ST_TRIP;
          err_nxt   = 1'b1;
          ev[ebs_pkg::INT_ERR] = 1'b1;
        end
      ebs_pkg::ST_STP_DLY:
        if (t_done)
          state_nxt = ebs_pkg::ST_DEC_ZERO;
      ebs_pkg::ST_DEC_ZERO:
        if (output_freq == '0)
        begin
          state_nxt = ebs_pkg::ST_IDLE;
          ev[ebs_pkg::INT_DONE] = 1'b1;
        end
      ebs_pkg::ST_TRIP:
        if (trip_clr)
        begin
          state_nxt = ebs_pkg::ST_IDLE;
          err_nxt   = 1'b0;
        end
      default:
      begin
        state_nxt = ebs_pkg::ST_TRIP;
        rel_nxt   = 1'b0;
        err_nxt   = 1'b1;
      end
    endcase
  end

  // Frequency steering and terminal outputs
  always_comb
  begin
    ovr_nxt  = 1'b1;
    hold_nxt = 1'b0;
    tgt_nxt  = '0;
    unique case (state_nxt)
      ebs_pkg::ST_ACC_REL, ebs_pkg::ST_REL_WAIT, ebs_pkg::ST_ACC_DLY:
        tgt_nxt = rel_freq_r;
      ebs_pkg::ST_CNF_ON, ebs_pkg::ST_CNF_OFF:
        hold_nxt = 1'b1;
      ebs_pkg::ST_DEC_BRK, ebs_pkg::ST_STP_DLY:
        tgt_nxt = brk_freq_r;
      ebs_pkg::ST_RUN, ebs_pkg::ST_IDLE:
        ovr_nxt = 1'b0;
      default:
        tgt_nxt = '0;
    endcase
    dcbi_nxt = (en_sel_r == ebs_pkg::EN_NODCB) & pos_ctrl_active;
    ta_nxt = (term_r[ebs_pkg::TERM_OA_LSB +: 8] == ebs_pkg::FN_RELEASE)
             ? rel_nxt
             : (term_r[ebs_pkg::TERM_OA_LSB +: 8] == ebs_pkg::FN_ERROR)
             & err_nxt;
    tb_nxt = (term_r[ebs_pkg::TERM_OB_LSB +: 8] == ebs_pkg::FN_RELEASE)
             ? rel_nxt
             : (term_r[ebs_pkg::TERM_OB_LSB +: 8] == ebs_pkg::FN_ERROR)
             & err_nxt;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r           <= ebs_pkg::ST_IDLE;
      rel_r             <= 1'b0;
      err_r             <= 1'b0;
      brake_release_out <= 1'b0;
      brake_error_out   <= 1'b0;
      brake_error_trip  <= 1'b0;
      out_term_a        <= 1'b0;
      out_term_b        <= 1'b0;
      freq_override     <= 1'b0;
      freq_hold         <= 1'b0;
      freq_target       <= '0;
      dc_brake_inhibit  <= 1'b0;
    end
    else
    begin
      state_r           <= state_nxt;
      rel_r             <= rel_nxt;
      err_r             <= err_nxt;
      brake_release_out <= rel_nxt;
      brake_error_out   <= err_nxt;
      brake_error_trip  <= err_nxt;
      out_term_a        <= ta_nxt;
      out_term_b        <= tb_nxt;
      freq_override     <= ovr_nxt;
      freq_hold         <= hold_nxt;
      freq_target       <= tgt_nxt;
      dc_brake_inhibit  <= dcbi_nxt;
    end
  end

  // APB slave, settings and interrupt logic
  always_comb
  begin
    en_sel_nxt   = en_sel_r;
    rel_wait_nxt = rel_wait_r;
    acc_dly_nxt  = acc_dly_r;
    stp_dly_nxt  = stp_dly_r;
    cnf_wait_nxt = cnf_wait_r;
    rel_freq_nxt = rel_freq_r;
    rel_cur_nxt  = rel_cur_r;
    brk_freq_nxt = brk_freq_r;
    term_nxt     = term_r;
    int_mask_nxt = int_mask_r;
    int_stat_nxt = int_stat_r;
    prdata_nxt   = prdata;
    pready_nxt   = 1'b0;
    pslverr_nxt  = 1'b0;
    if (wr_acc)
    begin
      unique case (paddr)
        ebs_pkg::OFS_CTRL:     en_sel_nxt   = pwdata[1:0];
        ebs_pkg::OFS_REL_WAIT: rel_wait_nxt = clamp_t(pwdata);
        ebs_pkg::OFS_ACC_DLY:  acc_dly_nxt  = clamp_t(pwdata);
        ebs_pkg::OFS_STP_DLY:  stp_dly_nxt  = clamp_t(pwdata);
        ebs_pkg::OFS_CNF_WAIT: cnf_wait_nxt = clamp_t(pwdata);
        ebs_pkg::OFS_REL_FREQ: rel_freq_nxt = clamp_f(pwdata);
        ebs_pkg::OFS_REL_CUR:  rel_cur_nxt  =
          (pwdata > 32'(ebs_pkg::CUR_MAX)) ? ebs_pkg::CUR_MAX : pwdata[4:0];
        ebs_pkg::OFS_BRK_FREQ: brk_freq_nxt = clamp_f(pwdata);
        ebs_pkg::OFS_TERM:     term_nxt     = pwdata[23:0];
        ebs_pkg::OFS_INT_STAT: int_stat_nxt = int_stat_r & ~pwdata[3:0];
        ebs_pkg::OFS_INT_MASK: int_mask_nxt = pwdata[3:0];
        default:               int_stat_nxt = int_stat_r;
      endcase
    end
    // Hardware set wins over a same-cycle clear
    int_stat_nxt = int_stat_nxt | ev;
    if (psel && !penable)
    begin
      pready_nxt = 1'b1;
      unique case (paddr)
        ebs_pkg::OFS_CTRL:     prdata_nxt = {30'h0, en_sel_r};
        ebs_pkg::OFS_REL_WAIT: prdata_nxt = {23'h0, rel_wait_r};
        ebs_pkg::OFS_ACC_DLY:  prdata_nxt = {23'h0, acc_dly_r};
        ebs_pkg::OFS_STP_DLY:  prdata_nxt = {23'h0, stp_dly_r};
        ebs_pkg::OFS_CNF_WAIT: prdata_nxt = {23'h0, cnf_wait_r};
        ebs_pkg::OFS_REL_FREQ: prdata_nxt = {16'h0, rel_freq_r};
        ebs_pkg::OFS_REL_CUR:  prdata_nxt = {27'h0, rel_cur_r};
        ebs_pkg::OFS_BRK_FREQ: prdata_nxt = {16'h0, brk_freq_r};
        ebs_pkg::OFS_TERM:     prdata_nxt = {8'h0, term_r};
        ebs_pkg::OFS_STATUS:   prdata_nxt = {27'h0, ab_assigned,
                                  state_r != ebs_pkg::ST_IDLE, ab_sync,
                                  err_r, rel_r};
        ebs_pkg::OFS_INT_STAT: prdata_nxt = {28'h0, int_stat_r};
        ebs_pkg::OFS_INT_MASK: prdata_nxt = {28'h0, int_mask_r};
        default:
        begin
          prdata_nxt  = 32'h0;
          pslverr_nxt = 1'b1;
        end
      endcase
    end
    irq_nxt = |(int_stat_nxt & int_mask_nxt);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_sel_r   <= ebs_pkg::EN_OFF;
      rel_wait_r <= '0;
      acc_dly_r  <= '0;
      stp_dly_r  <= '0;
      cnf_wait_r <= '0;
      rel_freq_r <= '0;
      rel_cur_r  <= '0;
      brk_freq_r <= '0;
      term_r     <= ebs_pkg::TERM_RST;
      int_stat_r <= '0;
      int_mask_r <= '0;
      prdata     <= 32'h0;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      irq        <= 1'b0;
    end
    else
    begin
      en_sel_r   <= en_sel_nxt;
      rel_wait_r <= rel_wait_nxt;
      acc_dly_r  <= acc_dly_nxt;
      stp_dly_r  <= stp_dly_nxt;
      cnf_wait_r <= cnf_wait_nxt;
      rel_freq_r <= rel_freq_nxt;
      rel_cur_r  <= rel_cur_nxt;
      brk_freq_r <= brk_freq_nxt;
      term_r     <= term_nxt;
      int_stat_r <= int_stat_nxt;
      int_mask_r <= int_mask_nxt;
      prdata     <= prdata_nxt;
      pready     <= pready_nxt;
      pslverr    <= pslverr_nxt;
      irq        <= irq_nxt;
    end
  end
endmodule : ebs_top
`default_nettype wire

// *** bench/ebs_brake_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module ebs_brake_model #(
  parameter int unsigned DLY = 6
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic release_in,
  input  wire logic stuck,
  output logic      answer_out
);
  logic [7:0] cnt_r;

  // Contact follows the release line after its travel time
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cnt_r      <= 8'h00;
      answer_out <= 1'b0;
    end
    else if (stuck || answer_out == release_in)
      cnt_r <= 8'h00;
    else if (cnt_r == 8'(DLY))
    begin
      answer_out <= release_in;
      cnt_r      <= 8'h00;
    end
    else
      cnt_r <= cnt_r + 8'h01;
endmodule : ebs_brake_model
`default_nettype wire

// *** bench/ebs_top_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
module ebs_top_chk #(
  parameter int unsigned TICK_CYCLES = ebs_pkg::TICK_CYCLES
) (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [7:0]                 paddr,
  input wire logic [31:0]                pwdata,
  input wire logic                       pready,
  input wire logic                       run_cmd,
  input wire logic                       pos_ctrl_active,
  input wire logic [ebs_pkg::FREQ_W-1:0] output_freq,
  input wire logic                       brake_release_out,
  input wire logic                       brake_error_out,
  input wire logic                       brake_error_trip,
  input wire logic [ebs_pkg::FREQ_W-1:0] freq_target,
  input wire logic                       dc_brake_inhibit
);
  logic clr;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Trip clear write seen on the bus
  assign clr = psel && penable && pwrite && paddr == ebs_pkg::OFS_CTRL
               && pwdata[ebs_pkg::CTRL_TRIP_CLR];

  AST_TRIP_EQ: assert property (brake_error_trip == brake_error_out)
    else $error("trip and error outputs differ");
  AST_ERR_HOLD: assert property (brake_error_out && !clr |=> brake_error_out)
    else $error("error output dropped without clear");
  AST_ERR_NOREL: assert property (brake_error_out |-> !brake_release_out)
    else $error("release on during error");
  AST_REL_RUN: assert property ($rose(brake_release_out) |-> $past(run_cmd))
    else $error("release without run command");
  AST_REL_FREQ: assert property ($rose(brake_release_out) |->
    $past(output_freq) >= $past(freq_target))
    else $error("release below release frequency");
  AST_OFF_FREQ: assert property ($fell(brake_release_out) && !brake_error_out
    |-> $past(output_freq) <= $past(freq_target))
    else $error("release dropped above braking frequency");
  AST_REL_KEEP: assert property (brake_release_out && run_cmd
    |=> brake_release_out || brake_error_out)
    else $error("release dropped while running");
  AST_DCB: assert property (dc_brake_inhibit |-> $past(pos_ctrl_active))
    else $error("inhibit without position control");
  AST_APB_RDY: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("bus answer not one cycle after setup");
endmodule : ebs_top_chk
`default_nettype wire

bind ebs_top ebs_top_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .run_cmd,
  .pos_ctrl_active, .output_freq, .brake_release_out, .brake_error_out,
  .brake_error_trip, .freq_target, .dc_brake_inhibit);

// *** bench/external_brake_sequencer_test.sv ***
`timescale 1ns/10ps
`default_nettype none
module external_brake_sequencer_test;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0]  paddr, output_current;
  logic [31:0] pwdata, prdata, q;
  logic        run_cmd, pos_ctrl_active, brake_answer_back_in, stuck, irq;
  logic        brake_release_out, brake_error_out, brake_error_trip;
  logic        out_term_a, out_term_b, freq_override, freq_hold;
  logic        dc_brake_inhibit;
  logic [15:0] output_freq, freq_target, cmd;
  int          n_errors, total_checks, n;

  ebs_top #(.TICK_CYCLES(4)) DUT (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .run_cmd, .pos_ctrl_active,
    .output_freq, .output_current, .brake_answer_back_in, .brake_release_out,
    .brake_error_out, .brake_error_trip, .out_term_a, .out_term_b,
    .freq_override, .freq_hold, .freq_target, .dc_brake_inhibit, .irq);
  ebs_brake_model #(.DLY(6)) u_brake (.pclk, .presetn, .stuck,
    .release_in(brake_release_out), .answer_out(brake_answer_back_in));

  always #25 pclk = ~pclk;

  // Motor ramps toward the commanded frequency unless held
  assign cmd = freq_override ? freq_target : (run_cmd ? 16'h0200 : 16'h0000);
  always @(posedge pclk)
    if (!freq_hold && cmd > output_freq)
      output_freq <= output_freq + 16'h0020;
    else if (!freq_hold && cmd < output_freq)
      output_freq <= output_freq - 16'h0020;

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chkb

  // One APB transfer, waiting for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    q = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k == 50)
    begin
      n_errors++;
      report_and_stop;
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd

  function automatic logic pick(input int s);
    case (s)
      0: return brake_release_out;
      1: return brake_error_out;
      2: return freq_override;
      default: return output_freq == 16'h0;
    endcase
  endfunction : pick

  // Waits until a watched output takes a level; n counts the cycles
  task automatic wait_for(input int s, input logic v);
    n = 0;
    while (pick(s) !== v && n < 3000)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 3000)
    begin
      n_errors++;
      report_and_stop;
    end
  endtask : wait_for

  task automatic clear_trip;
    run_cmd <= 1'b0;
    wr(8'h00, 32'h102);
    repeat (2) @(posedge pclk);
    chkb(brake_error_out, 1'b0);
    stuck <= 1'b0;
    wait_for(3, 1'b1);
    repeat (10) @(posedge pclk);
  endtask : clear_trip

  initial
  begin
    {pclk, presetn, psel, penable, pwrite, run_cmd, pos_ctrl_active} = '0;
    {paddr, pwdata, output_freq, stuck, n_errors, total_checks} = '0;
    output_current = 8'h05;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, unmapped place, saturation of settings
    rd(8'h20, 32'h141300);
    rd(8'h00, 32'h0);
    rd(8'h30, 32'h0);
    chkb(perr, 1'b1);
    wr(8'h04, 32'h1ff);
    rd(8'h04, 32'h1f4);
    wr(8'h14, 32'hffff);
    rd(8'h14, 32'he678);
    wr(8'h04, 32'h2);
    wr(8'h08, 32'h2);
    wr(8'h0c, 32'h2);
    wr(8'h10, 32'h3);
    wr(8'h14, 32'h100);
    wr(8'h18, 32'h5);
    wr(8'h1c, 32'h80);
    wr(8'h2c, 32'hf);
    // Every enable code, short run aborted early
    for (int c = 0; c < 3; c++)
    begin
      wr(8'h00, 32'(c));
      pos_ctrl_active <= 1'b1;
      repeat (3) @(posedge pclk);
      chkb(dc_brake_inhibit, c == 2);
      run_cmd <= 1'b1;
      repeat (6) @(posedge pclk);
      chkb(freq_override, c != 0);
      run_cmd <= 1'b0;
      wait_for(3, 1'b1);
      repeat (4) @(posedge pclk);
    end
    // Full cycle without answer-back, current at the threshold
    wr(8'h28, 32'hf);
    run_cmd <= 1'b1;
    wait_for(0, 1'b1);
    chk(output_freq, 32'h100);
    chk({16'h0, freq_target}, 32'h100);
    chkb(freq_hold, 1'b0);
    wait_for(2, 1'b0);
    chkb(n >= 8 && n <= 10, 1'b1);
    run_cmd <= 1'b0;
    wait_for(0, 1'b0);
    chk(output_freq, 32'h80);
    repeat (5) @(posedge pclk);
    chk(output_freq, 32'h80);
    wait_for(3, 1'b1);
    repeat (3) @(posedge pclk);
    rd(8'h28, 32'hb);
    chkb(irq, 1'b1);
    wr(8'h28, 32'hb);
    rd(8'h28, 32'h0);
    chkb(irq, 1'b0);
    // Answer-back assigned; contact sticks released on stop
    wr(8'h20, 32'h14132c);
    run_cmd <= 1'b1;
    wait_for(0, 1'b1);
    chkb(freq_hold, 1'b1);
    chkb(out_term_a, 1'b1);
    wait_for(2, 1'b0);
    chkb(brake_answer_back_in, 1'b1);
    stuck   <= 1'b1;
    run_cmd <= 1'b0;
    wait_for(0, 1'b0);
    chkb(freq_hold, 1'b1);
    wait_for(1, 1'b1);
    chkb(n >= 12 && n <= 14, 1'b1);
    chkb(brake_error_trip, 1'b1);
    chkb(out_term_b, 1'b1);
    clear_trip;
    // Contact never answers on start, error masked
    wr(8'h28, 32'hf);
    wr(8'h2c, 32'h2);
    stuck   <= 1'b1;
    run_cmd <= 1'b1;
    wait_for(0, 1'b1);
    wait_for(1, 1'b1);
    chkb(n >= 12 && n <= 14, 1'b1);
    chkb(brake_release_out, 1'b0);
    rd(8'h28, 32'h5);
    chkb(irq, 1'b0);
    wr(8'h2c, 32'hf);
    repeat (2) @(posedge pclk);
    chkb(irq, 1'b1);
    clear_trip;
    // Current one step below the threshold
    wr(8'h28, 32'hf);
    output_current <= 8'h04;
    run_cmd <= 1'b1;
    wait_for(1, 1'b1);
    chkb(brake_release_out, 1'b0);
    rd(8'h28, 32'h4);
    clear_trip;
    report_and_stop;
  end
endmodule : external_brake_sequencer_test
`default_nettype wire
